// [design/radio_link_ctrl.sv]
// Mode control, transmit/receive queues and acknowledge/retry engine.
// Assumes host-side controls on clock_i, the air interface on link_clk_i.
`timescale 1ns/1ns
module radio_link_ctrl
    import radio_link_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int DEPTH  = FIFO_DEPTH
)(
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  link_clk_i,
    input  wire logic                  link_rst_n_i,
    input  wire logic                  power_on_bit_i,
    input  wire logic                  primary_receive_bit_i,
    input  wire logic                  chip_enable_i,
    input  wire logic [PIPES-1:0]      auto_ack_en_i,
    input  wire logic [RETRY_W-1:0]    retry_limit_count_i,
    input  wire logic [ADDR_W-1:0]     tx_addr_i,
    input  wire logic [ADDR_W-1:0]     pipe0_addr_i,
    input  wire logic [HIGH_W-1:0]     pipe_high_addr_i,
    input  wire logic [5*LOW_W-1:0]    pipe_low_addr_i,
    input  wire logic                  tx_write_i,
    input  wire logic [DATA_W-1:0]     tx_data_i,
    input  wire logic                  rx_read_i,
    input  wire logic [2:0]            flag_clear_i,
    input  wire logic                  air_rx_valid_i,
    input  wire logic [ADDR_W-1:0]     air_rx_addr_i,
    input  wire logic [DATA_W-1:0]     air_rx_data_i,
    input  wire logic                  air_rx_ack_i,
    input  wire logic [7:0]            air_rx_crc_i,
    output logic                       tx_full_o,
    output logic                       rx_empty_o,
    output logic [DATA_W-1:0]          rx_data_o,
    output logic                       received_flag_o,
    output logic                       sent_complete_flag_o,
    output logic                       retry_limit_flag_o,
    output logic [PIPE_W-1:0]          rx_pipe_no_o,
    output logic [RETRY_W-1:0]         retry_count_o,
    output logic                       irq_n_o,
    output mode_t                      mode_o,
    output logic                       air_tx_valid_o,
    output logic [7:0]                 air_tx_preamble_o,
    output logic [ADDR_W-1:0]          air_tx_addr_o,
    output logic [DATA_W-1:0]          air_tx_data_o,
    output logic                       air_tx_ack_o,
    output logic [7:0]                 air_tx_crc_o
);
    localparam int IW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [WAIT_W-1:0] WAIT_LOAD = WAIT_W'(ACK_WAIT_CYC - 1);

    function automatic logic [IW-1:0] wrap(input logic [IW-1:0] i);
        return (i == IW'(DEPTH - 1)) ? '0 : i + 1'b1;
    endfunction

    // ================================================================
    // Input synchronisers
    logic [2:0] ce_s;
    logic       ce;
    logic [2:0] rx_evt_s;
    logic [2:0] done_s;
    logic       rx_evt;
    logic       done_evt;
    logic       link_done_tgl;
    logic       link_rx_tgl;

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            ce_s     <= 3'h0;
            ce       <= 1'b0;
            rx_evt_s <= 3'h0;
            done_s   <= 3'h0;
        end
        else
        begin
            ce_s     <= {ce_s[1:0], chip_enable_i};
            rx_evt_s <= {rx_evt_s[1:0], link_rx_tgl};
            done_s   <= {done_s[1:0], link_done_tgl};
            if (ce_s[1] == ce_s[2])
            begin
                ce <= ce_s[2];
            end
        end
    end
    assign rx_evt   = rx_evt_s[1] ^ rx_evt_s[2];
    assign done_evt = done_s[1] ^ done_s[2];

    // ================================================================
    // Pipe address match on the frame held by the link side
    logic [ADDR_W-1:0] pipe_addr [PIPES];
    logic [PIPES-1:0]  hit;
    logic [PIPE_W-1:0] hit_pipe;
    logic              crc_good;
    logic [ADDR_W-1:0] hold_addr;
    logic [DATA_W-1:0] hold_data;
    logic              hold_ack;
    logic [7:0]        hold_crc;

    genvar p;
    generate
        for (p = 0; p < PIPES; p++)
        begin : g_pipe
            if (p == 0)
            begin : g_full
                assign pipe_addr[p] = pipe0_addr_i;
            end
            else
            begin : g_short
                assign pipe_addr[p] = {pipe_high_addr_i, pipe_low_addr_i[(p-1)*LOW_W +: LOW_W]};
            end
            assign hit[p] = (hold_addr == pipe_addr[p]);
        end
    endgenerate

    always_comb
    begin
        hit_pipe = '0;
        for (int i = PIPES - 1; i >= 0; i--)
        begin
            if (hit[i])
            begin
                hit_pipe = PIPE_W'(i);
            end
        end
    end
    assign crc_good = (crc8(73'({hold_addr, hold_data, hold_ack})) == hold_crc);

    // ================================================================
    // Mode decisions
    mode_t             mode;
    logic [CW-1:0]     tx_count;
    logic [CW-1:0]     rx_count;
    logic [2:0]        flags;
    logic [RETRY_W-1:0] retry_cnt;
    logic [WAIT_W-1:0] wait_cnt;
    logic              ack_ok;
    logic              rx_ok;
    logic              start_new;
    logic              resend;
    logic              give_up;
    logic              finish;
    logic              send_ack;
    logic              can_start;

    assign can_start = ce && !primary_receive_bit_i && tx_count != 0 && !flags[FLAG_RT];
    assign ack_ok    = mode == TX_WAIT && rx_evt && crc_good && hold_ack && hit[0];
    assign rx_ok     = mode == RX_LISTEN && rx_evt && crc_good && !hold_ack && |hit;
    assign start_new = (mode == STBY_LOW || mode == ARMED) && can_start;
    assign resend    = mode == TX_WAIT && !ack_ok && wait_cnt == 0 && retry_cnt < retry_limit_count_i;
    assign give_up   = mode == TX_WAIT && !ack_ok && wait_cnt == 0 && retry_cnt >= retry_limit_count_i;
    assign finish    = ack_ok || (mode == TX_SEND && done_evt && !auto_ack_en_i[0]);
    assign send_ack  = rx_ok && auto_ack_en_i[hit_pipe];

    // Settings are plain inputs held by the host, so no mode clears them.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            mode <= PWR_DOWN;
        end
        else if (!power_on_bit_i)
        begin
            mode <= PWR_DOWN;
        end
        else
        begin
            unique case (mode)
                PWR_DOWN:
                    mode <= STBY_LOW;
                STBY_LOW, ARMED:
                    if (ce && primary_receive_bit_i)
                        mode <= RX_LISTEN;
                    else if (start_new)
                        mode <= TX_SEND;
                    else if (ce && !primary_receive_bit_i)
                        mode <= ARMED;
                    else
                        mode <= STBY_LOW;
                TX_SEND:
                    if (done_evt)
                        mode <= auto_ack_en_i[0] ? TX_WAIT : (ce ? ARMED : STBY_LOW);
                TX_WAIT:
                    if (resend)
                        mode <= TX_SEND;
                    else if (finish || give_up)
                        mode <= ce ? ARMED : STBY_LOW;
                RX_LISTEN:
                    if (!ce || !primary_receive_bit_i)
                        mode <= STBY_LOW;
                    else if (send_ack)
                        mode <= RX_ACK;
                RX_ACK:
                    if (done_evt)
                        mode <= RX_LISTEN;
                default:
                    mode <= PWR_DOWN;
            endcase
        end
    end
    assign mode_o = mode;

    // ================================================================
    // Retry and acknowledge-window counters
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            retry_cnt <= '0;
            wait_cnt  <= '0;
        end
        else
        begin
            if (start_new)
                retry_cnt <= '0;
            else if (resend)
                retry_cnt <= retry_cnt + 1'b1;
            if (mode == TX_SEND)
                wait_cnt <= WAIT_LOAD;
            else if (mode == TX_WAIT && wait_cnt != 0)
                wait_cnt <= wait_cnt - 1'b1;
        end
    end
    assign retry_count_o = retry_cnt;

    // ================================================================
    // Sticky flags; a set in the clearing cycle wins
    logic [2:0] set_flags;
    logic [2:0] next_flags;
    assign set_flags[FLAG_RX] = rx_ok && rx_count != FULL;
    assign set_flags[FLAG_TX] = finish;
    assign set_flags[FLAG_RT] = give_up;
    assign next_flags = (flags & ~flag_clear_i) | set_flags;

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            flags        <= FLAGS_RST;
            irq_n_o      <= 1'b1;
            rx_pipe_no_o <= '0;
        end
        else
        begin
            flags   <= next_flags;
            irq_n_o <= ~|next_flags;
            if (set_flags[FLAG_RX])
                rx_pipe_no_o <= hit_pipe;
        end
    end
    assign received_flag_o      = flags[FLAG_RX];
    assign sent_complete_flag_o = flags[FLAG_TX];
    assign retry_limit_flag_o   = flags[FLAG_RT];

    // ================================================================
    // Send queue: host writes, packets leave once acknowledged, or once sent if auto_ack_en_i[0] is off
    logic [DATA_W-1:0] tx_mem [DEPTH];
    logic [IW-1:0]     tx_wr;
    logic [IW-1:0]     tx_rd;
    logic              tx_push;
    logic [CW-1:0]     next_tx_count;
    assign tx_push = tx_write_i && tx_count != FULL;
    assign next_tx_count = tx_count + CW'(tx_push) - CW'(finish);

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            tx_wr     <= '0;
            tx_rd     <= '0;
            tx_count  <= '0;
            tx_full_o <= 1'b0;
        end
        else
        begin
            if (tx_push)
            begin
                tx_mem[tx_wr] <= tx_data_i;
                tx_wr         <= wrap(tx_wr);
            end
            if (finish)
                tx_rd <= wrap(tx_rd);
            tx_count  <= next_tx_count;
            tx_full_o <= next_tx_count == FULL;
        end
    end

    // ================================================================
    // Receive queue shared by all pipes
    logic [DATA_W-1:0] rx_mem [DEPTH];
    logic [IW-1:0]     rx_wr;
    logic [IW-1:0]     rx_rd;
    logic              rx_pop;
    logic [CW-1:0]     next_rx_count;
    assign rx_pop = rx_read_i && rx_count != 0;
    assign next_rx_count = rx_count + CW'(set_flags[FLAG_RX]) - CW'(rx_pop);

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            rx_wr      <= '0;
            rx_rd      <= '0;
            rx_count   <= '0;
            rx_empty_o <= 1'b1;
            rx_data_o  <= '0;
        end
        else
        begin
            if (set_flags[FLAG_RX])
            begin
                rx_mem[rx_wr] <= hold_data;
                rx_wr         <= wrap(rx_wr);
            end
            if (rx_pop)
            begin
                rx_data_o <= rx_mem[rx_rd];
                rx_rd     <= wrap(rx_rd);
            end
            rx_count   <= next_rx_count;
            rx_empty_o <= next_rx_count == 0;
        end
    end

    // ================================================================
    // Send request to the link side; fields stay still until done.
    logic              req_tgl;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_data;
    logic              req_ack;

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            req_tgl  <= 1'b0;
            req_addr <= '0;
            req_data <= '0;
            req_ack  <= 1'b0;
        end
        else if (power_on_bit_i && (start_new || resend))
        begin
            req_tgl  <= ~req_tgl;
            req_addr <= tx_addr_i;
            req_data <= tx_mem[tx_rd];
            req_ack  <= 1'b0;
        end
        else if (power_on_bit_i && send_ack)
        begin
            req_tgl  <= ~req_tgl;
            req_addr <= pipe_addr[hit_pipe];
            req_data <= '0;
            req_ack  <= 1'b1;
        end
    end

    // ================================================================
    // Link clock domain
    logic [2:0] req_s;
    logic [2:0] rx_back_s;
    logic       rx_back_tgl;
    logic       fire;
    assign fire = req_s[1] ^ req_s[2];

    always_ff @(posedge link_clk_i)
    begin
        if (!link_rst_n_i)
        begin
            req_s             <= 3'h0;
            link_done_tgl     <= 1'b0;
            air_tx_valid_o    <= 1'b0;
            air_tx_preamble_o <= 8'h00;
            air_tx_addr_o     <= '0;
            air_tx_data_o     <= '0;
            air_tx_ack_o      <= 1'b0;
            air_tx_crc_o      <= 8'h00;
        end
        else
        begin
            req_s          <= {req_s[1:0], req_tgl};
            air_tx_valid_o <= fire;
            if (fire)
            begin
                link_done_tgl     <= ~link_done_tgl;
                air_tx_preamble_o <= PREAMBLE;
                air_tx_addr_o     <= req_addr;
                air_tx_data_o     <= req_data;
                air_tx_ack_o      <= req_ack;
                air_tx_crc_o      <= crc8(73'({req_addr, req_data, req_ack}));
            end
        end
    end

    // A frame is held until the core has taken it; frames in between drop.
    always_ff @(posedge link_clk_i)
    begin
        if (!link_rst_n_i)
        begin
            rx_back_s   <= 3'h0;
            link_rx_tgl <= 1'b0;
            hold_addr   <= '0;
            hold_data   <= '0;
            hold_ack    <= 1'b0;
            hold_crc    <= 8'h00;
        end
        else
        begin
            rx_back_s <= {rx_back_s[1:0], rx_back_tgl};
            if (air_rx_valid_i && link_rx_tgl == rx_back_s[2])
            begin
                link_rx_tgl <= ~link_rx_tgl;
                hold_addr   <= air_rx_addr_i;
                hold_data   <= air_rx_data_i;
                hold_ack    <= air_rx_ack_i;
                hold_crc    <= air_rx_crc_i;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            rx_back_tgl <= 1'b0;
        else if (rx_evt)
            rx_back_tgl <= ~rx_back_tgl;
    end

    // ================================================================
    // Checks
    sequence s_ack_seen;
        mode == TX_WAIT && ack_ok;
    endsequence
    sequence s_timeout;
        mode == TX_WAIT && !ack_ok && wait_cnt == 0 && retry_cnt < retry_limit_count_i && power_on_bit_i;
    endsequence

    power_down_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !power_on_bit_i |=> mode == PWR_DOWN) else $error("not powered down");
    rx_entry_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        mode == STBY_LOW && ce && primary_receive_bit_i && power_on_bit_i
        |=> mode == RX_LISTEN) else $error("receive not entered");
    tx_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        mode == TX_SEND && !done_evt && power_on_bit_i |=> mode == TX_SEND)
        else $error("send left early");
    armed_idle_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        mode == ARMED && ce && !primary_receive_bit_i && tx_count == 0 && power_on_bit_i
        |=> mode == ARMED) else $error("armed state left");
    full_write_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        tx_count == FULL && tx_write_i && !finish |=> tx_count == FULL && tx_wr == $past(tx_wr))
        else $error("full queue written");
    retry_over_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        give_up |=> retry_limit_flag_o && !irq_n_o) else $error("retry limit missed");
    ack_done_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        s_ack_seen |=> sent_complete_flag_o && tx_rd == wrap($past(tx_rd)))
        else $error("acknowledge not applied");
    resend_step_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        s_timeout |=> mode == TX_SEND && retry_cnt == $past(retry_cnt) + 1'b1)
        else $error("no resend");
    flag_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        received_flag_o && !flag_clear_i[FLAG_RX] |=> received_flag_o [*2] or flag_clear_i[FLAG_RX])
        else $error("flag dropped");
    air_fire_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n_i)
        fire |=> air_tx_valid_o && air_tx_preamble_o == PREAMBLE ##1 !air_tx_valid_o)
        else $error("frame not sent");

endmodule // radio_link_ctrl

// [design/radio_link_pkg.sv]
// Constants, mode codes and the check-sum helper of the radio link engine.
// Assumes a 10 MHz core clock; the link side runs on a clock of its own.
package radio_link_pkg;

    // ================================================================
    // Sizes
    localparam int ADDR_W     = 40;
    localparam int PIPES      = 6;
    localparam int LOW_W      = 8;
    localparam int HIGH_W     = 32;
    localparam int FIFO_DEPTH = 3;
    localparam int RETRY_W    = 4;
    localparam int PIPE_W     = 3;

    // ================================================================
    // Timing
    localparam int CLK_MHZ      = 10;
    localparam int ACK_WAIT_US  = 250;
    localparam int ACK_WAIT_CYC = ACK_WAIT_US * CLK_MHZ;
    localparam int WAIT_W       = 12;

    // ================================================================
    // Flag positions and fixed values
    localparam int FLAG_RX = 0;
    localparam int FLAG_TX = 1;
    localparam int FLAG_RT = 2;
    localparam logic [7:0] PREAMBLE = 8'haa;
    localparam logic [2:0] FLAGS_RST = 3'h0;

    // Gray codes along power up, send, wait for acknowledge.
    typedef enum logic [2:0] {
        PWR_DOWN  = 3'h0,
        STBY_LOW  = 3'h1,
        ARMED     = 3'h3,
        TX_SEND   = 3'h2,
        TX_WAIT   = 3'h6,
        RX_LISTEN = 3'h7,
        RX_ACK    = 3'h5
    } mode_t;

    // CRC-8 (poly 0x07) over address, payload and the acknowledge bit.
    function automatic logic [7:0] crc8(input logic [72:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 72; i >= 0; i--)
        begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction

endpackage

// [tb/radio_peer.sv]
// Far radio node: sends frames on request and answers every frame it hears while ack_on_i is set.
// Assumes the engine's link clock; fields change 1 ns after its rising edge.
`timescale 1ns/1ns
module radio_peer
    import radio_link_pkg::*;
(
    input  wire logic              link_clk_i,
    input  wire logic              tx_valid_i,
    input  wire logic [ADDR_W-1:0] tx_addr_i,
    input  wire logic              ack_on_i,
    output logic                   valid_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic [31:0]            data_o,
    output logic                   ack_o,
    output logic [7:0]             crc_o
);
    // ================================================================
    // Frames
    function automatic logic [7:0] sum(input logic [72:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 72; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    // Idle fields are inverted so that nothing stale can pass for a frame.
    task automatic send(input logic [39:0] a, input logic [31:0] d, input logic k, input logic bad);
        @(posedge link_clk_i) #1;
        {valid_o, addr_o, data_o, ack_o} = {1'b1, a, d, k};
        crc_o = sum({a, d, k}) ^ {7'h00, bad};
        @(posedge link_clk_i) #1;
        {valid_o, addr_o, data_o, ack_o, crc_o} = {1'b0, ~a, ~d, ~k, ~crc_o};
    endtask
    initial {valid_o, addr_o, data_o, ack_o, crc_o} = '0;
    always @(posedge link_clk_i)
    begin
        if (tx_valid_i && ack_on_i)
        begin
            fork
                send(tx_addr_i, 32'h0, 1'b1, 1'b0);
            join_none
        end
    end
endmodule // radio_peer

// [tb/tb.sv]
// Self-checking bench of the radio link engine.
// Assumes radio_peer on the link side; host controls change at falling edges.
`timescale 1ns/1ns
module tb;
    import radio_link_pkg::*;
    // ================================================================
    // Wiring
    logic clock_i, link_clk_i, rst_n, pwr, primary_receiver, ce, txw, rxr, ack_on, pv, pk;
    logic full, empty, rflag, sflag, tflag, irq_n, tv, tk;
    logic [5:0] aae;
    logic [3:0] rlim, rcnt;
    logic [2:0] fclr, pno, flags;
    logic [39:0] txa, pla, ra, pa, ta;
    logic [31:0] pha, txd, d0, d2, rd, pd, rdata, td;
    logic [7:0] pc, tp, tc;
    mode_t mode;
    int errors, num_checks, cyc, frames, f;
    assign flags = {tflag, sflag, rflag};
    radio_link_ctrl DUT (
        .clock_i(clock_i), .rst_n_i(rst_n), .link_clk_i(link_clk_i), .link_rst_n_i(rst_n),
        .power_on_bit_i(pwr), .primary_receive_bit_i(primary_receiver), .chip_enable_i(ce), .auto_ack_en_i(aae),
        .retry_limit_count_i(rlim), .tx_addr_i(txa), .pipe0_addr_i(txa),
        .pipe_high_addr_i(pha), .pipe_low_addr_i(pla), .tx_write_i(txw), .tx_data_i(txd),
        .rx_read_i(rxr), .flag_clear_i(fclr), .air_rx_valid_i(pv), .air_rx_addr_i(pa),
        .air_rx_data_i(pd), .air_rx_ack_i(pk), .air_rx_crc_i(pc), .tx_full_o(full),
        .rx_empty_o(empty), .rx_data_o(rdata), .received_flag_o(rflag), .sent_complete_flag_o(sflag),
        .retry_limit_flag_o(tflag), .rx_pipe_no_o(pno), .retry_count_o(rcnt), .irq_n_o(irq_n),
        .mode_o(mode), .air_tx_valid_o(tv), .air_tx_preamble_o(tp), .air_tx_addr_o(ta),
        .air_tx_data_o(td), .air_tx_ack_o(tk), .air_tx_crc_o(tc));
    radio_peer peer (.link_clk_i(link_clk_i), .tx_valid_i(tv), .tx_addr_i(ta), .ack_on_i(ack_on),
        .valid_o(pv), .addr_o(pa), .data_o(pd), .ack_o(pk), .crc_o(pc));
    // ================================================================
    // Clocks, timeout and helpers
    initial
    begin
        clock_i = 0;
        forever #50 clock_i = ~clock_i;
    end
    initial
    begin
        link_clk_i = 0;
        #37;
        forever
        begin
            #62 link_clk_i = 1;
            #63 link_clk_i = 0;
        end
    end
    always @(posedge link_clk_i) if (tv === 1'b1) frames++;
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            errors++;
            give_verdict;
        end
    end
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
        num_checks++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkm(input mode_t e);
        num_checks++;
        if (mode !== e)
        begin
            errors++;
            $display("Error mode expected %s seen %s", e.name(), mode.name());
        end
    endtask
    task automatic waitm(input mode_t e);
        for (int i = 0; i < 300 && mode !== e; i++) @(negedge clock_i);
        chkm(e);
    endtask
    task automatic waitf(input int b);
        for (int i = 0; i < 8000 && flags[b] !== 1'b1; i++) @(negedge clock_i);
        chk("flag", 1, flags[b]);
    endtask
    task automatic push(input logic [31:0] d);
        @(negedge clock_i) {txw, txd} = {1'b1, d};
        @(negedge clock_i) txw = 0;
    endtask
    task automatic pulse(input logic [2:0] m, input logic r);
        @(negedge clock_i) {fclr, rxr} = {m, r};
        @(negedge clock_i) {fclr, rxr} = 4'h0;
    endtask
    // ================================================================
    // Tests
    initial
    begin
        {rst_n, pwr, primary_receiver, ce, txw, rxr, ack_on, aae, rlim, fclr, txd} = '0;
        void'($urandom(75010));
        pha = $urandom;
        pla = 40'h5544332211;
        txa = {32'($urandom), 8'h00};
        repeat (3) @(posedge clock_i);
        @(negedge clock_i) rst_n = 1;
        chkm(PWR_DOWN);
        chk("irq_n", 1, irq_n);
        chk("empty", 1, empty);
        chk("full", 0, full);
        $display("test reset done");
        pwr = 1;
        waitm(STBY_LOW);
        d0 = $urandom;
        d2 = $urandom;
        push(d0);
        push($urandom);
        push(d2);
        push($urandom);
        chk("full", 1, full);
        chkm(STBY_LOW);
        {aae, rlim, ack_on, ce} = {6'h01, 4'h3, 1'b1, 1'b1};
        waitm(TX_SEND);
        waitf(FLAG_TX);
        chk("irq_n", 0, irq_n);
        chk("preamble", 8'haa, tp);
        chk("tx data", d0, td);
        chk("tx crc", peer.sum({txa, d0, 1'b0}), tc);
        for (int i = 0; i < 2000 && frames < 3; i++) @(negedge clock_i);
        waitm(ARMED);
        chk("tx data", d2, td);
        chk("full", 0, full);
        pulse(3'h2, 1'b0);
        chk("irq_n", 1, irq_n);
        $display("test acknowledged send done");
        {ack_on, rlim} = {1'b0, 4'h1};
        d2 = $urandom;
        push(d2);
        waitf(FLAG_RT);
        chk("frames", 5, frames);
        chk("retry count", 1, rcnt);
        chk("irq_n", 0, irq_n);
        pwr = 0;
        waitm(PWR_DOWN);
        chk("kept flag", 1, tflag);
        pulse(3'h7, 1'b0);
        chk("irq_n", 1, irq_n);
        $display("test retry limit done");
        {pwr, primary_receiver, aae} = {1'b1, 1'b1, 6'h3f};
        waitm(RX_LISTEN);
        for (int p = 0; p < 6; p++)
        begin
            ra = (p == 0) ? txa : {pha, pla[8*p-8 +: 8]};
            rd = $urandom;
            f = frames;
            peer.send(ra, rd, 1'b0, 1'b0);
            waitf(FLAG_RX);
            chk("pipe", p, pno);
            chk("irq_n", 0, irq_n);
            pulse(3'h1, 1'b1);
            chk("rx data", rd, rdata);
            for (int i = 0; i < 100 && frames == f; i++) @(negedge clock_i);
            chk("ack addr", ra, ta);
            chk("ack bit", 1, tk);
        end
        peer.send(txa, $urandom, 1'b0, 1'b1);
        repeat (20) @(negedge clock_i);
        chk("bad frame", 0, rflag);
        pulse(3'h0, 1'b1);
        chk("empty", 1, empty);
        chk("rx data", rd, rdata);
        $display("test receive pipes done");
        // The packet left by the retry test is still queued and goes out without acknowledge.
        {aae, primary_receiver} = 7'h00;
        waitm(TX_SEND);
        f = frames;
        ce = 0;
        repeat (4) @(negedge clock_i);
        chkm(TX_SEND);
        waitf(FLAG_TX);
        chkm(STBY_LOW);
        chk("frames", f + 1, frames);
        chk("kept data", d2, td);
        chk("retry count", 0, rcnt);
        $display("test enable drop done");
        give_verdict;
    end
endmodule // tb
